// file: src/xor_swap_datapath_slice.sv
// Datapath slice running the immediate XOR, file XOR and nibble swap operations.
// Assumes the decoder holds a request for one cycle with i_valid, and the file register
// array returns the byte at i_addr combinationally on i_file_rdata in that same cycle.
// Writes reach the array one edge after the request, and nothing is forwarded here:
// a decoder that reads back a byte in the cycle after writing it must forward it itself.
// Requests may follow each other every cycle; each one sees the previous accumulator.
// Widths are fixed at one byte and a 128-entry file; other values are refused.
`timescale 1ns/10ps
module xor_swap_datapath_slice #(
  parameter int DW = datapath_pkg::DATA_W,
  parameter int AW = datapath_pkg::ADDR_W
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire logic                    i_valid,
  input  wire logic [1:0]              i_op,
  input  wire logic [DW-1:0]           i_imm,
  input  wire logic [AW-1:0]           i_addr,
  input  wire logic                    i_dest,
  input  wire logic [DW-1:0]           i_file_rdata,
  output logic      [DW-1:0]           o_acc,
  output logic                         o_zero,
  output logic                         o_file_we,
  output logic      [AW-1:0]           o_file_waddr,
  output logic      [DW-1:0]           o_file_wdata,
  output logic                         o_done,
  output logic                         o_bad_op
);
  import datapath_pkg::*;

  // The nibble swap and the flag logic are written for one byte and a 128-entry file
  if (DW != 8 || AW != 7) begin : g_width_check
    $error("xor_swap_datapath_slice serves only an 8-bit datapath with 7-bit addresses");
  end

  alu_bus_if alu ();

  result_unit u_result (
    .bus (alu.unit)
  );

  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic       zero_r;
  logic       zero_nxt;
  logic       we_r;
  logic       we_nxt;
  logic [6:0] waddr_r;
  logic [7:0] wdata_r;
  logic       done_r;
  logic       bad_r;

  // Request decode; an unused code decodes to nothing but its own pulse, so a
  // stray code from the decoder cannot disturb the accumulator or the file
  wire is_xor_imm  = i_valid & (i_op == OPC_XOR_IMM);
  wire is_xor_file = i_valid & (i_op == OPC_XOR_FILE);
  wire is_swap     = i_valid & (i_op == OPC_SWAP);
  wire is_bad      = i_valid & (i_op == OPC_UNUSED);
  wire is_xor      = is_xor_imm | is_xor_file;
  wire uses_file   = is_xor_file | is_swap;
  wire to_file     = uses_file & (i_dest == DEST_FILE);
  wire to_acc      = is_xor_imm | (uses_file & (i_dest == DEST_ACC));

  // Operand steering into the result unit
  assign alu.op = i_op;
  assign alu.a  = acc_r;
  assign alu.b  = is_xor_imm ? i_imm : i_file_rdata;

  // Next-state selection; swap never touches the zero flag
  assign acc_nxt  = to_acc ? alu.result : acc_r;
  assign zero_nxt = is_xor ? alu.zero : zero_r;
  assign we_nxt   = to_file;

  // Architectural state: accumulator and zero flag
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      acc_r  <= ACC_RST;
      zero_r <= ZERO_RST;
    end else begin
      acc_r  <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // File write port, registered so the array sees a clean one-cycle strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      we_r    <= 1'h0;
      waddr_r <= ADDR_RST;
      wdata_r <= ACC_RST;
    end else begin
      we_r    <= we_nxt;
      waddr_r <= to_file ? i_addr : waddr_r;
      wdata_r <= to_file ? alu.result : wdata_r;
    end
  end

  // Completion and bad-code pulses; an unused code changes no state but its own bad-code pulse
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      done_r <= 1'h0;
      bad_r  <= 1'h0;
    end else begin
      done_r <= is_xor | is_swap;
      bad_r  <= is_bad;
    end
  end

  // Data outputs come straight from the flip-flops above
  assign o_acc        = acc_r;
  assign o_zero       = zero_r;
  assign o_file_we    = we_r;
  assign o_file_waddr = waddr_r;
  assign o_file_wdata = wdata_r;
  assign o_done       = done_r;
  assign o_bad_op     = bad_r;

  // Checks; the file data is sampled with the request since the array may change after it
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  xor_imm_acc_a: assert property (
    is_xor_imm |=> (o_acc == ($past(acc_r) ^ $past(i_imm))) && !o_file_we)
    else $error("immediate XOR did not land in the accumulator");

  xor_file_zero_a: assert property (
    is_xor_file |=> o_zero == ((($past(acc_r) ^ $past(i_file_rdata))) == 8'h00))
    else $error("file XOR zero flag wrong");

  xor_file_back_a: assert property (
    is_xor_file && i_dest |=> o_file_we && o_file_waddr == $past(i_addr)
      && o_file_wdata == ($past(acc_r) ^ $past(i_file_rdata)) && o_acc == $past(acc_r))
    else $error("file XOR write-back wrong");

  xor_file_acc_a: assert property (
    is_xor_file && !i_dest |=> !o_file_we
      && o_acc == ($past(acc_r) ^ $past(i_file_rdata)))
    else $error("file XOR to accumulator wrong");

  swap_flags_a: assert property (
    is_swap |=> o_zero == $past(zero_r))
    else $error("nibble swap altered the zero flag");

  swap_file_a: assert property (
    is_swap && i_dest |=> o_file_we && o_file_waddr == $past(i_addr)
      && o_file_wdata == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])})
    else $error("nibble swap write-back wrong");

  swap_acc_a: assert property (
    is_swap && !i_dest |=> !o_file_we
      && o_acc == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])})
    else $error("nibble swap to accumulator wrong");

  zero_exact_a: assert property (
    is_xor |=> o_zero == (o_file_we ? (o_file_wdata == 8'h00) : (o_acc == 8'h00)))
    else $error("zero flag does not match XOR result");

  idle_hold_a: assert property (
    !i_valid || is_bad |=> $stable(o_acc) && $stable(o_zero) && !o_file_we && !o_done)
    else $error("state changed without a valid operation");

  done_pulse_a: assert property (
    is_xor || is_swap |=> o_done ##1 (o_done == $past(is_xor || is_swap)))
    else $error("completion pulse mistimed");

  // Flag and accumulator checks taken from the inputs, not the result unit
  imm_zero_a: assert property (
    is_xor_imm |=> o_zero == (($past(acc_r) ^ $past(i_imm)) == 8'h00))
    else $error("immediate XOR zero flag wrong");

  swap_keep_acc_a: assert property (
    is_swap && i_dest |=> o_acc == $past(acc_r) && o_zero == $past(zero_r))
    else $error("nibble swap to file disturbed the accumulator");

  acc_hold_a: assert property (
    !to_acc |=> o_acc == $past(acc_r))
    else $error("accumulator changed without an operation aimed at it");

  // Each operation sees the accumulator left by the one just before it
  chain_acc_a: assert property (
    is_swap && !i_dest ##1 is_xor_imm |=> o_acc == ($past(i_imm)
      ^ {$past(i_file_rdata[3:0], 2), $past(i_file_rdata[7:4], 2)}))
    else $error("back-to-back operation missed the previous result");

  bad_op_quiet_a: assert property (
    is_bad |=> o_bad_op && !o_done && !o_file_we)
    else $error("unused operation code not refused cleanly");

  legal_no_bad_a: assert property (
    is_xor || is_swap |=> !o_bad_op)
    else $error("legal operation flagged as bad");

  port_hold_a: assert property (
    !to_file |=> $stable(o_file_waddr) && $stable(o_file_wdata))
    else $error("file write port changed without a write");

  we_done_a: assert property (
    o_file_we |-> o_done)
    else $error("file write without a completion pulse");

  // Looks at reset itself, so the default disable is switched off here
  reset_clear_a: assert property (disable iff (1'b0)
    !i_nrst |=> o_acc == ACC_RST && o_zero == ZERO_RST && !o_file_we && !o_done
      && !o_bad_op && o_file_waddr == ADDR_RST && o_file_wdata == ACC_RST)
    else $error("outputs not cleared by reset");

  // Main scenarios the bench must reach
  xor_zero_c: cover property (is_xor ##1 o_zero);
  file_wb_c:  cover property (is_xor_file && i_dest ##1 o_file_we);
  swap_acc_c: cover property (is_swap && !i_dest ##1 is_xor_imm);
  bad_op_c:   cover property (is_bad ##1 o_bad_op);
  swap_wb_c:  cover property (is_swap && i_dest ##1 o_file_we);

endmodule

// file: src/datapath_pkg.sv
// Constants, operation codes and helper functions for the XOR and nibble-swap slice.
// Assumes the decoder presents one operation per cycle, qualified by a valid strobe.
package datapath_pkg;

  // Operation codes presented by the instruction decoder
  localparam logic [1:0] OPC_XOR_IMM  = 2'h0;  // xor_immediate_op
  localparam logic [1:0] OPC_XOR_FILE = 2'h1;  // xor_file_op
  localparam logic [1:0] OPC_SWAP     = 2'h2;  // nibble_swap_op
  localparam logic [1:0] OPC_UNUSED   = 2'h3;  // Ignored, flagged as bad

  // Destination selector encodings
  localparam logic DEST_ACC  = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // Widths and values after reset
  localparam int         DATA_W     = 8;
  localparam int         ADDR_W     = 7;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic       ZERO_RST   = 1'h0;
  localparam logic [6:0] ADDR_RST   = 7'h00;
  localparam int         LATENCY    = 1;   // Cycles from request to registered result

  // Exchange the upper and lower halves of a byte
  function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
    swap_nibbles = {v[3:0], v[7:4]};
  endfunction

  // Zero detect on an eight-bit result
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

endpackage

// file: src/alu_bus_if.sv
// Carrier between the slice controller and its combinational result unit.
// Assumes both ends sit in the same clock domain; no timing of its own.
`timescale 1ns/10ps
interface alu_bus_if;
  logic [1:0] op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] result;
  logic       zero;

  modport ctrl (output op, output a, output b, input result, input zero);
  modport unit (input op, input a, input b, output result, output zero);
endinterface

// file: src/result_unit.sv
// Combinational result unit: XOR of two operands or nibble swap of the second.
// Assumes operands are stable for the cycle in which the controller samples them.
`timescale 1ns/10ps
module result_unit (
  alu_bus_if.unit bus
);
  import datapath_pkg::*;

  logic [7:0] xor_val;
  logic [7:0] swap_val;
  logic       is_swap;

  // Both candidates are built in parallel; selection keeps the path short
  assign xor_val    = bus.a ^ bus.b;
  assign swap_val   = swap_nibbles(bus.b);
  assign is_swap    = (bus.op == OPC_SWAP);
  assign bus.result = is_swap ? swap_val : xor_val;
  assign bus.zero   = is_zero(bus.result);
endmodule

// file: bench/file_array_model.sv
// File register array model: 128 bytes, combinational read, write at the clock edge.
// Assumes the slice raises its write strobe for one cycle per write.
`timescale 1ns/10ps
module file_array_model (
  input  wire logic       i_clk,
  input  wire logic       i_we,
  input  wire logic [6:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [6:0] i_raddr,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [128];
  // Known pattern so the bench can predict every byte
  initial for (int k = 0; k < 128; k++) mem[k] = 8'(k * 13 + 7);
  // No forwarding, as in the real array
  assign o_rdata = mem[i_raddr];
  always @(posedge i_clk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule

// file: bench/xor_swap_datapath_slice_bench.sv
// Self-checking bench for the XOR and nibble-swap slice.
// Assumes the array model answers reads in the request cycle.
`timescale 1ns/10ps
module xor_swap_datapath_slice_bench;
  import datapath_pkg::*;
  logic       clk = 1'h0, nrst = 1'h0, valid = 1'h0, dest = 1'h0;
  logic [1:0] opc = 2'h0;
  logic [7:0] imm = 8'h00, rdata, acc, wdata;
  logic [6:0] addr = 7'h00, waddr;
  logic       zero, we, done, bad;
  logic [7:0] acc_m = 8'h00;
  logic       zero_m = 1'h0;
  int         errors = 0, samples_checked = 0;
  always #25 clk = ~clk;
  xor_swap_datapath_slice dut_u (.i_clk(clk), .i_nrst(nrst), .i_valid(valid), .i_op(opc),
    .i_imm(imm), .i_addr(addr), .i_dest(dest), .i_file_rdata(rdata), .o_acc(acc),
    .o_zero(zero), .o_file_we(we), .o_file_waddr(waddr), .o_file_wdata(wdata),
    .o_done(done), .o_bad_op(bad));
  file_array_model far_u (.i_clk(clk), .i_we(we), .i_waddr(waddr), .i_wdata(wdata),
    .i_raddr(addr), .o_rdata(rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One request, then an idle cycle so no read follows a write to the same byte
  task automatic run_op(input logic [1:0] o, input logic [7:0] k, input logic [6:0] a,
                        input logic d);
    logic [7:0] src, res;
    logic       legal, to_file;
    src = far_u.mem[a];
    legal = (o != OPC_UNUSED);
    res = (o == OPC_SWAP) ? {src[3:0], src[7:4]} : acc_m ^ ((o == OPC_XOR_IMM) ? k : src);
    to_file = (o == OPC_XOR_FILE || o == OPC_SWAP) && d;
    @(posedge clk) #2;
    valid = 1'h1;
    opc = o;
    imm = k;
    addr = a;
    dest = d;
    @(posedge clk) #2;
    valid = 1'h0;
    if (legal && !to_file) acc_m = res;
    if (legal && o != OPC_SWAP) zero_m = (res == 8'h00);
    check({7'h0, bad}, {7'h0, !legal});
    check({7'h0, done}, {7'h0, legal});
    check(acc, acc_m);
    check({7'h0, zero}, {7'h0, zero_m});
    check({7'h0, we}, {7'h0, to_file});
    if (to_file) check(wdata, res);
    if (to_file) check({1'h0, waddr}, {1'h0, a});
    @(posedge clk) #2;
    check(far_u.mem[a], to_file ? res : src);
  endtask
  // Immediate XOR over boundary values, i_dest ignored, then a zero result
  task automatic t_imm;
    logic [7:0] vals [3] = '{8'h00, 8'hff, 8'ha5};
    foreach (vals[i]) run_op(OPC_XOR_IMM, vals[i], 7'h01, i[0]);
    run_op(OPC_XOR_IMM, acc_m, 7'h01, 1'h1);
    $display("immediate xor test done");
  endtask
  // File XOR at both address ends, both destinations, then a zero into the file
  task automatic t_file;
    run_op(OPC_XOR_FILE, 8'h00, 7'h7f, 1'h0);
    run_op(OPC_XOR_FILE, 8'h00, 7'h00, 1'h1);
    run_op(OPC_XOR_IMM, acc_m ^ far_u.mem[3], 7'h00, 1'h0);
    run_op(OPC_XOR_FILE, 8'h00, 7'h03, 1'h1);
    $display("file xor test done");
  endtask
  // Swap with the zero flag set, so a flag change would show
  task automatic t_swap;
    run_op(OPC_SWAP, 8'h00, 7'h10, 1'h0);
    run_op(OPC_SWAP, 8'h00, 7'h7e, 1'h1);
    run_op(OPC_UNUSED, 8'h3c, 7'h05, 1'h1);
    $display("swap and unused op test done");
  endtask
  // Swap into the accumulator, then an immediate XOR in the very next cycle
  task automatic t_chain;
    logic [7:0] src;
    src = far_u.mem[7'h20];
    @(posedge clk) #2;
    valid = 1'h1;
    opc = OPC_SWAP;
    addr = 7'h20;
    dest = 1'h0;
    @(posedge clk) #2;
    opc = OPC_XOR_IMM;
    imm = 8'h5a;
    acc_m = {src[3:0], src[7:4]};
    check(acc, acc_m);
    check({7'h0, zero}, {7'h0, zero_m});
    @(posedge clk) #2;
    valid = 1'h0;
    acc_m = acc_m ^ 8'h5a;
    zero_m = (acc_m == 8'h00);
    check(acc, acc_m);
    check({7'h0, zero}, {7'h0, zero_m});
    check({7'h0, done}, 8'h01);
    @(posedge clk) #2;
    check({7'h0, done}, 8'h00);
    $display("back to back test done");
  endtask
  // Reset in mid-run returns every output to its value after reset
  task automatic t_reset;
    @(posedge clk) #2;
    nrst = 1'h0;
    @(posedge clk) #2;
    nrst = 1'h1;
    acc_m = ACC_RST;
    zero_m = ZERO_RST;
    check(acc, ACC_RST);
    check({7'h0, zero}, {7'h0, ZERO_RST});
    check({1'h0, waddr}, {1'h0, ADDR_RST});
    check(wdata, ACC_RST);
    check({5'h0, we, done, bad}, 8'h00);
    run_op(OPC_XOR_FILE, 8'h00, 7'h40, 1'h0);
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #2 nrst = 1'h1;
    check(acc, ACC_RST);
    check({7'h0, zero}, {7'h0, ZERO_RST});
    t_imm();
    t_file();
    t_swap();
    t_chain();
    t_reset();
    conclude();
  end
  // Tests need about 54 cycles; 4000 cycles leave a wide margin
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
